// ==== src/wfs_sequencer.sv ====
// waveform playback sequencer with apb register file and trace memory
`timescale 1ns/1ns
`default_nettype none
module wfs_sequencer
  import wfs_pkg::*;
(
  input  wire logic                 pclk,         // 250 MHz clock
  input  wire logic                 presetn,      // async reset, active low
  input  wire logic                 psel,         // apb select
  input  wire logic                 penable,      // apb access phase
  input  wire logic                 pwrite,       // apb direction
  input  wire logic [7:0]           paddr,        // apb byte address
  input  wire logic [31:0]          pwdata,       // apb write data
  output logic      [31:0]          prdata,       // apb read data
  output logic                      pready,       // apb ready
  output logic                      pslverr,      // apb unmapped address
  input  wire logic                 ext_trig_in,  // external trigger pin
  input  wire logic                 hs_trig_in,   // handshake trigger pin
  output logic                      hs_ready_out, // handshake ready pin
  output logic                      trig_out,     // pulse per produced sample
  output logic [NCH-1:0][SW-1:0]    chan_out      // channel sample values
);
  // trace memory, one flat array of channel and index
  logic [SW-1:0] mem [NCH*(1<<IW)];

  // registers
  logic [CTW-1:0] ctrl_reg, ctrl_next;
  logic [PW-1:0]  points_per_segment_reg, points_per_segment_next;
  logic [15:0]    sample_rate_setting_reg, sample_rate_setting_next;
  logic [31:0]    repeat_rate_setting_reg, repeat_rate_setting_next;
  logic [QW-1:0]  sequence_trigger_mode_reg, sequence_trigger_mode_next;
  logic [CW+IW-1:0] waddr_reg, waddr_next;
  logic [IW-1:0]  rd_ptr_reg, rd_ptr_next, rd_end_reg, rd_end_next;
  logic [CW-1:0]  rd_ch_reg, rd_ch_next;
  logic           rd_done_reg, rd_done_next;
  logic [31:0]    prdata_reg, prdata_next;
  logic           pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic           mem_we;

  // playback state
  wfs_state_t     st_reg, st_next;
  logic [IW-1:0]  idx_reg, idx_next, step_idx;
  logic [15:0]    div_reg, div_next;
  logic [31:0]    rep_reg, rep_next;
  logic [QW-1:0]  seg_reg, seg_next, seg_after;
  logic           seq_started_reg, seq_started_next;
  logic [NCH-1:0][SW-1:0] chan_reg, chan_next;
  logic           trig_out_reg, hs_pin_reg, hs_pin_next;
  logic           step, ready_now;

  // decoded controls and helpers
  logic           run, rep_en, seq_cont, fmt_bin, hti, hri;
  logic [1:0]     mode, src;
  logic           ext_ev, hs_ev, ev, sample_ext, last, pace, rep_ok;
  logic           at_end, new_seq, need_ev, start_ok, cfg_err;
  logic           wr_acc, rd_acc;
  logic [26:0]    wave_per;
  logic [SW-1:0]  rd_raw;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < NIB_TEN) ? (ASC_DIG + {4'h0, n}) : (ASC_LET + {4'h0, n});
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      A_CTRL, A_POINTS, A_SRATE, A_RRATE, A_SEQLEN, A_STATUS,
      A_WPER, A_WADDR, A_WDATA, A_RRANGE, A_RDATA: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // trigger pins, handshake polarity from configuration
  wfs_trig_sync u_ext_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin_in      (ext_trig_in),
    .act_high    (1'b1),
    .event_pulse (ext_ev)
  );
  wfs_trig_sync u_hs_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin_in      (hs_trig_in),
    .act_high    (hti),
    .event_pulse (hs_ev)
  );

  // field decode
  assign run      = ctrl_reg[C_RUN];
  assign mode     = ctrl_reg[C_MODE +: 2];
  assign src      = ctrl_reg[C_SRC +: 2];
  assign rep_en   = ctrl_reg[C_REP];
  assign seq_cont = ctrl_reg[C_SEQC];
  assign fmt_bin  = ctrl_reg[C_FMT];
  assign hti      = ctrl_reg[C_HTI];
  assign hri      = ctrl_reg[C_HRI];
  assign wr_acc   = psel && penable && pready_reg && pwrite;
  assign rd_acc   = psel && penable && pready_reg && !pwrite;
  // product never passes 27 bits: 1024 points times 16-bit period
  assign wave_per = 27'(points_per_segment_reg) * 27'(sample_rate_setting_reg);
  assign cfg_err  = rep_en && (repeat_rate_setting_reg < {5'h00, wave_per});
  assign rd_raw   = mem[{rd_ch_reg, rd_ptr_reg}];

  // apb slave: ready registered, so every access has one wait-free access phase
  always_comb begin
    ctrl_next                  = ctrl_reg;
    points_per_segment_next    = points_per_segment_reg;
    sample_rate_setting_next   = sample_rate_setting_reg;
    repeat_rate_setting_next   = repeat_rate_setting_reg;
    sequence_trigger_mode_next = sequence_trigger_mode_reg;
    waddr_next   = waddr_reg;
    rd_ptr_next  = rd_ptr_reg;
    rd_end_next  = rd_end_reg;
    rd_ch_next   = rd_ch_reg;
    rd_done_next = rd_done_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel && !penable;
    pslverr_next = 1'b0;
    mem_we       = 1'b0;
    if (psel && !penable) begin
      pslverr_next = !addr_ok(paddr);
      case (paddr)
        A_CTRL:   prdata_next = {22'h000000, ctrl_reg};
        A_POINTS: prdata_next = {21'h000000, points_per_segment_reg};
        A_SRATE:  prdata_next = {16'h0000, sample_rate_setting_reg};
        A_RRATE:  prdata_next = repeat_rate_setting_reg;
        A_SEQLEN: prdata_next = {19'h00000, sequence_trigger_mode_reg};
        A_STATUS: begin
          prdata_next          = 32'h00000000;
          prdata_next[S_BUSY]  = (st_reg != ST_IDLE);
          prdata_next[S_READY] = hs_pin_reg ~^ hri;
          prdata_next[S_CFGE]  = cfg_err;
          prdata_next[S_RDONE] = rd_done_reg;
          prdata_next[S_SEG +: QW] = seg_reg;
        end
        A_WPER:   prdata_next = {5'h00, wave_per};
        A_WADDR:  prdata_next = {19'h00000, waddr_reg};
        A_RDATA:  prdata_next = fmt_bin ? {{16{rd_raw[SW-1]}}, rd_raw} :
                                {hex_char(rd_raw[15:12]), hex_char(rd_raw[11:8]),
                                 hex_char(rd_raw[7:4]), hex_char(rd_raw[3:0])};
        default:  prdata_next = 32'h00000000;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        A_CTRL:   ctrl_next = pwdata[CTW-1:0];
        A_POINTS: begin
          if (pwdata > 32'(MAX_POINTS)) points_per_segment_next = MAX_POINTS;
          else if (pwdata[PW-1:0] == 11'h000) points_per_segment_next = 11'h001;
          else points_per_segment_next = pwdata[PW-1:0];
        end
        A_SRATE:  sample_rate_setting_next = (pwdata[15:0] == 16'h0000) ?
                                             16'h0001 : pwdata[15:0];
        A_RRATE:  repeat_rate_setting_next = (pwdata == 32'h00000000) ?
                                             32'h00000001 : pwdata;
        A_SEQLEN: begin
          if (pwdata > 32'(MAX_SEQ)) sequence_trigger_mode_next = MAX_SEQ;
          else if (pwdata[QW-1:0] == 13'h0000) sequence_trigger_mode_next = 13'h0001;
          else sequence_trigger_mode_next = pwdata[QW-1:0];
        end
        A_WADDR:  waddr_next = {pwdata[WA_CH +: CW], pwdata[IW-1:0]};
        A_WDATA:  begin
          mem_we     = 1'b1;
          waddr_next = {waddr_reg[CW+IW-1:IW], waddr_reg[IW-1:0] + 10'h001};
        end
        A_RRANGE: begin
          rd_ch_next   = pwdata[RR_CH +: CW];
          rd_done_next = 1'b0;
          if (pwdata[RR_GIVEN]) begin
            rd_ptr_next = pwdata[RR_FIRST +: IW];
            rd_end_next = (pwdata[RR_LAST +: IW] < pwdata[RR_FIRST +: IW]) ?
                          pwdata[RR_FIRST +: IW] : pwdata[RR_LAST +: IW];
          end else begin
            rd_ptr_next = 10'h000;
            rd_end_next = IW'(points_per_segment_reg - 11'h001);
          end
        end
        default: ;
      endcase
    end
    // each data read moves on one point; the last point repeats when done
    if (rd_acc && paddr == A_RDATA) begin
      if (rd_ptr_reg == rd_end_reg) rd_done_next = 1'b1;
      else rd_ptr_next = rd_ptr_reg + 10'h001;
    end
  end

  // trace memory write port, no reset on storage
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[waddr_reg] <= pwdata[SW-1:0];
    end
  end

  // playback: one shared pacing and start decision for every channel
  always_comb begin
    sample_ext = (mode == M_SAMPLE) && (src != SRC_IMM);
    case (src)
      SRC_IMM:  ev = 1'b1;
      SRC_EXT:  ev = ext_ev;
      SRC_HAND: ev = hs_ev;
      default:  ev = 1'b0;
    endcase
    last      = (idx_reg == IW'(points_per_segment_reg - 11'h001));
    pace      = sample_ext ? ev : (div_reg == 16'h0000);
    rep_ok    = !rep_en || (rep_reg == 32'h00000000);
    at_end    = (st_reg == ST_RUN) && pace && last;
    seg_after = (st_reg == ST_RUN) ? seg_reg + 13'h0001 : seg_reg;
    new_seq   = (mode == M_SEQ) && ((st_reg == ST_WAIT) ? (seg_reg == 13'h0000) :
                                    (seg_after >= sequence_trigger_mode_reg));
    if (sample_ext) need_ev = 1'b1;
    else if (mode == M_SEGMENT) need_ev = 1'b1;
    else if (new_seq) need_ev = !(seq_started_reg && seq_cont);
    else need_ev = 1'b0;
    start_ok = need_ev ? ev : rep_ok;
    st_next          = st_reg;
    idx_next         = idx_reg;
    seg_next         = seg_reg;
    seq_started_next = seq_started_reg;
    div_next  = (div_reg != 16'h0000) ? div_reg - 16'h0001 : div_reg;
    rep_next  = (rep_reg != 32'h00000000) ? rep_reg - 32'h00000001 : rep_reg;
    step      = 1'b0;
    step_idx  = idx_reg;
    case (st_reg)
      ST_IDLE: begin
        if (run) begin
          st_next          = ST_WAIT;
          seg_next         = 13'h0000;
          seq_started_next = 1'b0;
          rep_next         = 32'h00000000;
        end
      end
      ST_WAIT, ST_RUN: begin
        if (st_reg == ST_RUN && pace && !last) begin
          idx_next = idx_reg + 10'h001;
          step     = 1'b1;
          step_idx = idx_reg + 10'h001;
          div_next = sample_rate_setting_reg - 16'h0001;
        end else if (st_reg == ST_WAIT || at_end) begin
          st_next = ST_WAIT;
          if (at_end) seg_next = new_seq ? 13'h0000 : seg_after;
          if (start_ok) begin
            st_next  = ST_RUN;
            idx_next = 10'h000;
            step     = 1'b1;
            step_idx = 10'h000;
            div_next = sample_rate_setting_reg - 16'h0001;
            rep_next = repeat_rate_setting_reg - 32'h00000001;
            if (new_seq) seq_started_next = 1'b1;
          end
        end
        if (!run) begin
          st_next  = ST_IDLE;
          seg_next = 13'h0000; // no stale count when a later run picks sequence mode
          step     = 1'b0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // outputs change only on a produced sample, else hold
    for (int c = 0; c < NCH; c++) begin
      chan_next[c] = step ? mem[{CW'(c), step_idx}] : chan_reg[c];
    end
    ready_now   = run && (src == SRC_HAND) && need_ev &&
                  ((st_reg == ST_WAIT) || (st_reg == ST_RUN && sample_ext));
    hs_pin_next = ready_now ? hri : !hri;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg                  <= CTRL_RST;
      points_per_segment_reg    <= POINTS_RST;
      sample_rate_setting_reg   <= SRATE_RST;
      repeat_rate_setting_reg   <= RRATE_RST;
      sequence_trigger_mode_reg <= SEQ_RST;
      waddr_reg       <= 13'h0000;
      rd_ptr_reg      <= 10'h000;
      rd_end_reg      <= 10'h000;
      rd_ch_reg       <= 3'h0;
      rd_done_reg     <= 1'h0;
      prdata_reg      <= 32'h00000000;
      pready_reg      <= 1'h0;
      pslverr_reg     <= 1'h0;
      st_reg          <= ST_IDLE;
      idx_reg         <= 10'h000;
      div_reg         <= 16'h0000;
      rep_reg         <= 32'h00000000;
      seg_reg         <= 13'h0000;
      seq_started_reg <= 1'h0;
      chan_reg        <= {NCH{16'h0000}};
      trig_out_reg    <= 1'h0;
      hs_pin_reg      <= 1'h1;
    end else begin
      ctrl_reg                  <= ctrl_next;
      points_per_segment_reg    <= points_per_segment_next;
      sample_rate_setting_reg   <= sample_rate_setting_next;
      repeat_rate_setting_reg   <= repeat_rate_setting_next;
      sequence_trigger_mode_reg <= sequence_trigger_mode_next;
      waddr_reg       <= waddr_next;
      rd_ptr_reg      <= rd_ptr_next;
      rd_end_reg      <= rd_end_next;
      rd_ch_reg       <= rd_ch_next;
      rd_done_reg     <= rd_done_next;
      prdata_reg      <= prdata_next;
      pready_reg      <= pready_next;
      pslverr_reg     <= pslverr_next;
      st_reg          <= st_next;
      idx_reg         <= idx_next;
      div_reg         <= div_next;
      rep_reg         <= rep_next;
      seg_reg         <= seg_next;
      seq_started_reg <= seq_started_next;
      chan_reg        <= chan_next;
      trig_out_reg    <= step;
      hs_pin_reg      <= hs_pin_next;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign trig_out     = trig_out_reg;
  assign hs_ready_out = hs_pin_reg;
  assign chan_out     = chan_reg;

  // checks on playback and register behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_sample_a: assert property (!$stable(chan_reg) |-> trig_out_reg)
    else $error("channel output changed without a sample");
  points_clamp_a: assert property ((points_per_segment_reg <= MAX_POINTS) &&
    (points_per_segment_reg != 11'h000)) else $error("points out of range");
  seg_hold_a: assert property ((st_reg == ST_WAIT) && ($past(st_reg) == ST_WAIT) |->
    $stable(chan_reg)) else $error("output moved while waiting");
  seq_count_a: assert property ((seg_reg < sequence_trigger_mode_reg) ||
    (mode != M_SEQ)) else $error("segment count beyond sequence length");
  seq_nogap_a: assert property (run && at_end && new_seq && seq_cont &&
    seq_started_reg && !rep_en && !sample_ext |=> trig_out_reg)
    else $error("gap between continuous sequences");
  sample_period_a: assert property (trig_out_reg && !sample_ext && run &&
    $stable(ctrl_reg) && $stable(sample_rate_setting_reg) |->
    (div_reg == sample_rate_setting_reg - 16'h0001)) else $error("sample timer not reloaded");
  ext_step_a: assert property (sample_ext && !ev |=> !trig_out_reg)
    else $error("sample produced without trigger");
  reset_default_a: assert property ($rose(presetn) |-> (src == SRC_IMM) && !fmt_bin)
    else $error("wrong source or format after reset");
  ready_busy_a: assert property ((st_reg == ST_RUN) && !sample_ext && run |=>
    (hs_ready_out == !hri)) else $error("ready asserted during playback");
  abort_a: assert property (!run |=> (st_reg == ST_IDLE) && !trig_out_reg)
    else $error("playback not aborted");
  rd_default_a: assert property (wr_acc && paddr == A_RRANGE && !pwdata[RR_GIVEN] |=>
    (rd_ptr_reg == 10'h000) && (rd_end_reg == IW'(points_per_segment_reg - 11'h001)))
    else $error("default readback range wrong");

  seq_done_c: cover property (at_end && new_seq && run);
  ext_sample_c: cover property (sample_ext && trig_out_reg);
  hs_ready_c: cover property (ready_now && hs_ev);
  bin_read_c: cover property (rd_acc && paddr == A_RDATA && fmt_bin);
endmodule
`default_nettype wire

// ==== src/wfs_pkg.sv ====
// shared constants, register map and types of the waveform playback sequencer
package wfs_pkg;
  // geometry
  localparam int NCH = 8;                       // output channels
  localparam int SW  = 16;                      // sample width
  localparam int IW  = 10;                      // point index width
  localparam int CW  = 3;                       // channel index width
  localparam int PW  = 11;                      // points register width
  localparam int QW  = 13;                      // sequence length width
  localparam logic [PW-1:0] MAX_POINTS = 11'h400;
  localparam logic [QW-1:0] MAX_SEQ    = 13'h1000;

  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_POINTS = 8'h04;
  localparam logic [7:0] A_SRATE  = 8'h08;
  localparam logic [7:0] A_RRATE  = 8'h0c;
  localparam logic [7:0] A_SEQLEN = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_WPER   = 8'h18;
  localparam logic [7:0] A_WADDR  = 8'h1c;
  localparam logic [7:0] A_WDATA  = 8'h20;
  localparam logic [7:0] A_RRANGE = 8'h24;
  localparam logic [7:0] A_RDATA  = 8'h28;

  // control register fields
  localparam int C_RUN  = 0;                    // continuous_run_control
  localparam int C_MODE = 1;                    // trigger mode, 2 bits
  localparam int C_SRC  = 3;                    // trigger source, 2 bits
  localparam int C_REP  = 5;                    // repetition timer enable
  localparam int C_SEQC = 6;                    // sequences back to back
  localparam int C_FMT  = 7;                    // readback binary format
  localparam int C_HTI  = 8;                    // handshake trigger invert
  localparam int C_HRI  = 9;                    // handshake ready invert
  localparam int CTW    = 10;

  // status register fields
  localparam int S_BUSY  = 0;
  localparam int S_READY = 1;
  localparam int S_CFGE  = 2;
  localparam int S_RDONE = 3;
  localparam int S_SEG   = 16;

  // readback range and write address fields
  localparam int RR_FIRST = 0;
  localparam int RR_LAST  = 16;
  localparam int RR_CH    = 28;
  localparam int RR_GIVEN = 31;
  localparam int WA_CH    = 12;

  // trigger modes and sources
  localparam logic [1:0] M_FREE    = 2'h0;
  localparam logic [1:0] M_SAMPLE  = 2'h1;
  localparam logic [1:0] M_SEGMENT = 2'h2;
  localparam logic [1:0] M_SEQ     = 2'h3;
  localparam logic [1:0] SRC_IMM   = 2'h0;
  localparam logic [1:0] SRC_EXT   = 2'h1;
  localparam logic [1:0] SRC_HAND  = 2'h2;

  // reset values
  localparam logic [CTW-1:0] CTRL_RST  = 10'h000;
  localparam logic [PW-1:0]  POINTS_RST = 11'h400;
  localparam logic [15:0]    SRATE_RST  = 16'h0001;
  localparam logic [31:0]    RRATE_RST  = 32'h00000001;
  localparam logic [QW-1:0]  SEQ_RST    = 13'h0001;

  // ascii digits for text readback
  localparam logic [7:0] ASC_DIG = 8'h30;
  localparam logic [7:0] ASC_LET = 8'h57;
  localparam logic [3:0] NIB_TEN = 4'ha;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} wfs_state_t;
endpackage

// ==== src/wfs_trig_sync.sv ====
// three-stage synchroniser and single-edge detector for a trigger pin
`timescale 1ns/1ns
`default_nettype none
module wfs_trig_sync (
  input  wire logic pclk,        // system clock
  input  wire logic presetn,     // async reset, active low
  input  wire logic pin_in,      // raw asynchronous pin
  input  wire logic act_high,    // level that counts as asserted
  output logic      event_pulse  // one cycle per asserting edge
);
  logic s1_reg, s2_reg, s3_reg, stable_reg, pulse_reg;
  logic stable_next, pulse_next;

  // stable level moves only once stages two and three agree
  always_comb begin
    stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
    pulse_next  = (stable_next != stable_reg) && (stable_next == act_high);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg     <= 1'h0;
      s2_reg     <= 1'h0;
      s3_reg     <= 1'h0;
      stable_reg <= 1'h0;
      pulse_reg  <= 1'h0;
    end else begin
      s1_reg     <= pin_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
      pulse_reg  <= pulse_next;
    end
  end

  assign event_pulse = pulse_reg;

  single_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    event_pulse |=> !event_pulse) else $error("trigger event longer than one cycle");
endmodule
`default_nettype wire

// ==== tb/wfs_uut_model.sv ====
// unit under test model driving the external and handshake trigger pins
`timescale 1ns/1ns
`default_nettype none
module wfs_uut_model (
  input  wire logic pclk,         // system clock
  input  wire logic fire,         // bench asks for one trigger event
  input  wire logic hs_ready_out, // ready from the sequencer, low active
  output logic      ext_trig_in,  // rising edge marks an event
  output logic      hs_trig_in    // falling edge marks an event
);
  // idle levels at time zero, then one event per request; one process drives both pins
  initial begin
    ext_trig_in = 1'b0;
    hs_trig_in  = 1'b1;
    forever begin
      @(posedge fire);
      @(posedge pclk);
      ext_trig_in <= 1'b1;
      if (hs_ready_out === 1'b0) hs_trig_in <= 1'b0;
      // held wide so the synchroniser sees one clean edge
      repeat (6) @(posedge pclk);
      ext_trig_in <= 1'b0;
      hs_trig_in  <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_waveform_playback_sequencer.sv ====
// self-checking bench for the waveform playback sequencer
`timescale 1ns/1ns
`default_nettype none
module test_waveform_playback_sequencer;
  import wfs_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite, fire, serr;
  logic                  pready, pslverr, ext_trig_in, hs_trig_in, hs_ready_out, trig_out;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [NCH-1:0][SW-1:0] chan_out;
  int                    err_count = 0, total_checks = 0, n;
  wfs_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_trig_in, .hs_trig_in, .hs_ready_out, .trig_out, .chan_out);
  wfs_uut_model i_uut (.pclk, .fire, .hs_ready_out, .ext_trig_in, .hs_trig_in);
  // 250 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish(input int extra);
    err_count += extra;
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; idle edge after it so psel is never rewritten in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 9);
    rd = prdata;
    serr = pslverr;
    if (k == 9) tally_and_finish(1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // edges until the next sample pulse
  task automatic wtrig(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (trig_out !== 1'b1 && c < 60);
    if (c == 60) tally_and_finish(1);
  endtask
  task automatic cnt(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge pclk);
      if (trig_out === 1'b1) c++;
    end
  endtask
  task automatic t_regs;
    chk("ready_idle", hs_ready_out, 1);
    apb(0, A_CTRL, 0);
    chk("ctrl_rst", rd, 0);
    apb(1, A_POINTS, 32'h7d0);
    apb(0, A_POINTS, 0);
    chk("points_clamp", rd, 32'h400);
    apb(1, A_SEQLEN, 32'h1388);
    apb(0, A_SEQLEN, 0);
    chk("seq_clamp", rd, 32'h1000);
    apb(1, 8'h40, 1);
    chk("unmapped_err", serr, 1);
  endtask
  task automatic t_free;
    apb(1, A_WADDR, 0);
    apb(1, A_WDATA, 32'h1234);
    apb(1, A_WDATA, 32'h5678);
    apb(1, A_WADDR, 32'h7000);
    apb(1, A_WDATA, 32'h0abc);
    apb(1, A_POINTS, 2);
    apb(1, A_SRATE, 2);
    apb(1, A_CTRL, 1);
    wtrig(n);
    chk("ch0_pt0", chan_out[0], 32'h1234);
    chk("ch7_pt0", chan_out[7], 32'h0abc);
    wtrig(n);
    chk("sample_gap", n, 2);
    chk("ch0_pt1", chan_out[0], 32'h5678);
    wtrig(n);
    chk("segment_gap", n, 2);
    chk("wrap_pt0", chan_out[0], 32'h1234);
    apb(1, A_CTRL, 0);
    cnt(20, n);
    chk("halt_pulses", n, 0);
  endtask
  // text readback of the whole segment, then one point in binary
  task automatic t_read;
    apb(1, A_RRANGE, 0);
    apb(0, A_RDATA, 0);
    chk("text_pt0", rd, 32'h31323334);
    apb(0, A_RDATA, 0);
    apb(0, A_RDATA, 0);
    chk("text_last", rd, 32'h35363738);
    apb(1, A_RRANGE, 32'hf0000000);
    apb(0, A_RDATA, 0);
    chk("text_hex", rd, 32'h30616263);
    apb(1, A_CTRL, 32'h80);
    apb(1, A_RRANGE, 32'h80000001);
    apb(0, A_RDATA, 0);
    chk("bin_pt1", rd, 32'h00005678);
  endtask
  task automatic t_trig;
    apb(1, A_CTRL, 32'h0b);
    cnt(12, n);
    chk("ext_no_pace", n, 0);
    fire <= 1'b1;
    cnt(20, n);
    fire <= 1'b0;
    chk("ext_one_step", n, 1);
    apb(1, A_CTRL, 32'h13);
    cnt(4, n);
    chk("hs_ready", hs_ready_out, 0);
    fire <= 1'b1;
    cnt(20, n);
    fire <= 1'b0;
    chk("hs_one_step", n, 1);
  endtask
  // repetition timer, then one externally started sequence and one segment
  task automatic t_rep_seq;
    apb(1, A_CTRL, 0);
    apb(1, A_RRATE, 32'h0a);
    apb(1, A_CTRL, 32'h21);
    wtrig(n);
    wtrig(n);
    wtrig(n);
    chk("repeat_gap", n, 32'h8);
    apb(1, A_CTRL, 32'h20);
    apb(0, A_WPER, 0);
    chk("wave_period", rd, 32'h4);
    apb(1, A_RRATE, 32'h3);
    apb(0, A_STATUS, 0);
    chk("cfg_flag", rd[S_CFGE], 1);
    apb(1, A_SEQLEN, 32'h2);
    apb(1, A_CTRL, 32'h0f);
    fire <= 1'b1;
    cnt(40, n);
    fire <= 1'b0;
    chk("seq_samples", n, 32'h4);
    chk("seq_hold", chan_out[0], 32'h5678);
    apb(1, A_CTRL, 32'h0d);
    fire <= 1'b1;
    cnt(20, n);
    fire <= 1'b0;
    chk("seg_samples", n, 32'h2);
  endtask
  // reset, then the scenarios in order
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_free;
    t_read;
    t_trig;
    t_rep_seq;
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
